// ---- design/kli_defs.svh ----
// Register indices, field positions and reset values of the keyboard unit
`ifndef KLI_DEFS_SVH
`define KLI_DEFS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define KLI_IDX_LEVEL 8'h9C
`define KLI_IDX_ENABLE 8'h9D
`define KLI_IDX_FLAGS 8'h9E
`define KLI_IDX_CLEAR 8'h9F
`define KLI_IDX_GIEN 8'hB1

// ----------------------------------------------------------------------
// Widths, fields and reset values
// ----------------------------------------------------------------------
`define KLI_LINES 8
`define KLI_ADDR_W 12
`define KLI_DATA_W 32
`define KLI_IDX_LSB 2
`define KLI_GIEN_BIT 0
`define KLI_STRB_LOW 0
`define KLI_RST_BYTE 8'h00
`define KLI_RST_BIT 1'b0
`define KLI_ZERO_HI 24'h000000
`define KLI_ZERO_WORD 32'h00000000
`define KLI_ZERO_GIEN_HI 31'h00000000
`define KLI_ALL_LINES 8'hFF

`endif

// ---- design/kli_pkg.sv ----
// Types shared by the keyboard level interrupt unit
package kli_pkg;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef logic [7:0] kli_byte_t;

    typedef enum logic [5:0]
    {
        KLI_R_NONE = 6'b000001,
        KLI_R_LEVEL = 6'b000010,
        KLI_R_ENABLE = 6'b000100,
        KLI_R_FLAGS = 6'b001000,
        KLI_R_CLEAR = 6'b010000,
        KLI_R_GIEN = 6'b100000
    } kli_reg_t;

endpackage : kli_pkg

// ---- design/kli_line.sv ----
// One keyboard line: level match and sticky flag
`include "kli_defs.svh"

module kli_line
(
    input wire logic sys_clk, // Core clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic pin, // Port line level
    input wire logic level_sel, // 0 detects low, 1 detects high
    input wire logic sw_clear, // Software clear pulse for this flag
    output logic match, // Pin shows the programmed level
    output logic flag // Sticky line flag
);

    logic flag_ff;
    logic nxt_flag_ff;

    // ------------------------------------------------------------------
    // Detection and flag
    // ------------------------------------------------------------------
    assign match = ~(pin ^ level_sel); // [R5]

    always_comb
    begin
        // Detection beats a clear so a held key is never lost
        if (match)
            nxt_flag_ff = 1'b1; // [R1] [R9]
        else if (sw_clear)
            nxt_flag_ff = 1'b0;
        else
            nxt_flag_ff = flag_ff;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            flag_ff <= `KLI_RST_BIT;
        else
            flag_ff <= nxt_flag_ff;
    end

    assign flag = flag_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_set_wins_clear: assert property (@(posedge sys_clk) // [R9]
        disable iff (!reset_n)
        (match && sw_clear) |=> flag_ff)
        else $error("flag lost when detection met clear");

    a_clear_drops: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!match && sw_clear) |=> !flag_ff)
        else $error("flag not cleared by software");

endmodule : kli_line

// ---- design/kli_top.sv ----
// Keyboard level interrupt unit with APB register slave
//
// Functional notes
// (R1) Each line's flag sets when its pin shows the programmed level.
// (R2) Request rises when any flag is set on an enabled line.
// (R3) Software clears flags; hardware never clears them itself.
// (R4) Enable bit zero leaves pin as plain port; one lets flag interrupt.
// (R5) Level select zero detects low level, one detects high level.
// (R6) Level, enable and flag registers at indices 9C, 9D, 9E; reset zero.
// (R7) Combined request is also gated by one global keyboard enable bit.
// (R8) Enabled lines at programmed level wake the core from idle/power down.
// (R9) Detection and clear in the same cycle leave the flag set.
`include "kli_defs.svh"

module kli_top
(
    input wire logic sys_clk, // Core clock, 125 MHz
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction, 1 writes
    input wire logic [`KLI_ADDR_W-1:0] paddr, // APB byte address
    input wire logic [`KLI_DATA_W-1:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [`KLI_DATA_W-1:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic [`KLI_LINES-1:0] port_one_in, // Port pin levels
    output logic [`KLI_LINES-1:0] key_line_alt, // Line serves keyboard
    output logic keypad_irq_request, // Shared keyboard interrupt
    output logic wake_request // Wake from idle or power down
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic kli_pkg::kli_reg_t decode_reg
    (
        input logic [`KLI_ADDR_W-1:0] addr
    );
        kli_pkg::kli_reg_t sel;
        sel = kli_pkg::KLI_R_NONE;
        if (addr[`KLI_IDX_LSB-1:0] == 2'h0)
        begin
            case (addr[`KLI_ADDR_W-1:`KLI_IDX_LSB])
                {2'h0, `KLI_IDX_LEVEL}: sel = kli_pkg::KLI_R_LEVEL;
                {2'h0, `KLI_IDX_ENABLE}: sel = kli_pkg::KLI_R_ENABLE;
                {2'h0, `KLI_IDX_FLAGS}: sel = kli_pkg::KLI_R_FLAGS;
                {2'h0, `KLI_IDX_CLEAR}: sel = kli_pkg::KLI_R_CLEAR;
                {2'h0, `KLI_IDX_GIEN}: sel = kli_pkg::KLI_R_GIEN;
                default: sel = kli_pkg::KLI_R_NONE;
            endcase
        end
        return sel;
    endfunction : decode_reg

    kli_pkg::kli_reg_t reg_sel;
    logic access;
    logic setup;
    logic wr_en;
    logic wr_level;
    logic wr_enable;
    logic wr_flags;
    logic wr_clear;
    logic wr_gien;

    assign reg_sel = decode_reg(paddr);
    assign access = psel && penable;
    assign setup = psel && !penable;
    assign wr_en = access && pwrite && pstrb[`KLI_STRB_LOW];
    assign wr_level = wr_en && (reg_sel == kli_pkg::KLI_R_LEVEL); // [R6]
    assign wr_enable = wr_en && (reg_sel == kli_pkg::KLI_R_ENABLE); // [R6]
    assign wr_flags = wr_en && (reg_sel == kli_pkg::KLI_R_FLAGS); // [R6]
    assign wr_clear = wr_en && (reg_sel == kli_pkg::KLI_R_CLEAR);
    assign wr_gien = wr_en && (reg_sel == kli_pkg::KLI_R_GIEN);

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    kli_pkg::kli_byte_t level_ff;
    kli_pkg::kli_byte_t nxt_level_ff;
    kli_pkg::kli_byte_t enable_ff;
    kli_pkg::kli_byte_t nxt_enable_ff;
    logic gien_ff;
    logic nxt_gien_ff;

    always_comb
    begin
        nxt_level_ff = wr_level ? pwdata[7:0] : level_ff;
        nxt_enable_ff = wr_enable ? pwdata[7:0] : enable_ff;
        nxt_gien_ff = wr_gien ? pwdata[`KLI_GIEN_BIT] : gien_ff;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            level_ff <= `KLI_RST_BYTE; // [R6]
            enable_ff <= `KLI_RST_BYTE; // [R6]
            gien_ff <= `KLI_RST_BIT;
        end
        else
        begin
            level_ff <= nxt_level_ff;
            enable_ff <= nxt_enable_ff;
            gien_ff <= nxt_gien_ff;
        end
    end

    // ------------------------------------------------------------------
    // Lines
    // ------------------------------------------------------------------
    // Writing a zero to the flag register or a one to the clear register
    // drops that flag; both paths exist so software may pick either.
    kli_pkg::kli_byte_t sw_clear;
    kli_pkg::kli_byte_t match_vec;
    kli_pkg::kli_byte_t flags;

    assign sw_clear = ({`KLI_LINES{wr_flags}} & ~pwdata[7:0])
        | ({`KLI_LINES{wr_clear}} & pwdata[7:0]);

    genvar gi;
    generate
        for (gi = 0; gi < `KLI_LINES; gi++)
        begin : g_line
            kli_line u_line
            (
                .sys_clk(sys_clk),
                .reset_n(reset_n),
                .pin(port_one_in[gi]),
                .level_sel(level_ff[gi]),
                .sw_clear(sw_clear[gi]),
                .match(match_vec[gi]),
                .flag(flags[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Requests
    // ------------------------------------------------------------------
    kli_pkg::kli_byte_t pending;
    logic irq_ff;
    logic nxt_irq_ff;

    assign pending = flags & enable_ff; // [R2]
    assign key_line_alt = enable_ff; // [R4]

    always_comb
    begin
        nxt_irq_ff = gien_ff && (|pending); // [R2] [R7]
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            irq_ff <= `KLI_RST_BIT;
        else
            irq_ff <= nxt_irq_ff;
    end

    assign keypad_irq_request = irq_ff;

    // Kept combinational: in power down the clock may be stopped, so the
    // live pin match must reach the wake logic without a clock edge.
    assign wake_request = |(pending | (match_vec & enable_ff)); // [R8]

    // ------------------------------------------------------------------
    // APB read path
    // ------------------------------------------------------------------
    logic [`KLI_DATA_W-1:0] rdata_ff;
    logic [`KLI_DATA_W-1:0] nxt_rdata_ff;

    always_comb
    begin
        nxt_rdata_ff = rdata_ff;
        if (setup && !pwrite)
        begin
            case (reg_sel)
                kli_pkg::KLI_R_LEVEL: nxt_rdata_ff = {`KLI_ZERO_HI, level_ff};
                kli_pkg::KLI_R_ENABLE:
                    nxt_rdata_ff = {`KLI_ZERO_HI, enable_ff};
                kli_pkg::KLI_R_FLAGS: nxt_rdata_ff = {`KLI_ZERO_HI, flags};
                kli_pkg::KLI_R_GIEN:
                    nxt_rdata_ff = {`KLI_ZERO_GIEN_HI, gien_ff};
                default: nxt_rdata_ff = `KLI_ZERO_WORD;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            rdata_ff <= `KLI_ZERO_WORD;
        else
            rdata_ff <= nxt_rdata_ff;
    end

    assign prdata = rdata_ff;
    assign pready = 1'b1;
    assign pslverr = access && (reg_sel == kli_pkg::KLI_R_NONE);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_flag_sets_match: assert property (@(posedge sys_clk) // [R1]
        disable iff (!reset_n)
        (|match_vec) |=> ((flags & $past(match_vec)) == $past(match_vec)))
        else $error("matching line did not set its flag");

    a_flag_sticky_hold: assert property (@(posedge sys_clk) // [R3]
        disable iff (!reset_n)
        !(wr_flags || wr_clear) |=> ((flags & $past(flags)) == $past(flags)))
        else $error("flag dropped without software clear");

    a_irq_follows_line: assert property (@(posedge sys_clk) // [R2]
        disable iff (!reset_n)
        (gien_ff && |(flags & enable_ff)) |=> keypad_irq_request)
        else $error("enabled flag raised no request");

    a_irq_masked_line: assert property (@(posedge sys_clk) // [R2]
        disable iff (!reset_n)
        ((flags & enable_ff) == `KLI_RST_BYTE) |=> !keypad_irq_request)
        else $error("request from disabled lines only");

    a_global_gate_off: assert property (@(posedge sys_clk) // [R7]
        disable iff (!reset_n)
        !gien_ff |=> !keypad_irq_request)
        else $error("request despite global enable off");

    a_alt_mode_write: assert property (@(posedge sys_clk) // [R4]
        disable iff (!reset_n)
        wr_enable |=> (key_line_alt == $past(pwdata[7:0])))
        else $error("line mode not taken from enable write");

    a_level_low_all: assert property (@(posedge sys_clk) // [R5]
        disable iff (!reset_n)
        (level_ff == `KLI_RST_BYTE && port_one_in == `KLI_RST_BYTE)
        |=> (flags == `KLI_ALL_LINES))
        else $error("low level not detected");

    a_level_high_all: assert property (@(posedge sys_clk) // [R5]
        disable iff (!reset_n)
        (level_ff == `KLI_ALL_LINES && port_one_in == `KLI_ALL_LINES)
        |=> (flags == `KLI_ALL_LINES))
        else $error("high level not detected");

    a_read_upper_zero: assert property (@(posedge sys_clk) // [R6]
        disable iff (!reset_n)
        (setup && !pwrite && reg_sel == kli_pkg::KLI_R_LEVEL)
        |=> (prdata == {`KLI_ZERO_HI, $past(level_ff)}))
        else $error("level register read back wrong");

    a_wake_enabled: assert property (@(posedge sys_clk) // [R8]
        disable iff (!reset_n)
        |(flags & enable_ff) |-> wake_request)
        else $error("enabled flag gave no wake");

    c_irq_raised: cover property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(keypad_irq_request));

    c_clear_collide: cover property (@(posedge sys_clk) disable iff (!reset_n)
        |(sw_clear & match_vec));

    c_unmapped: cover property (@(posedge sys_clk) disable iff (!reset_n)
        pslverr);

endmodule : kli_top

// ---- verification/kli_keypad.sv ----
// Behavioural matrix keypad that drives the port pins of the unit
module kli_keypad
(
    input wire logic [7:0] key_down, // One bit per closed key
    output logic [7:0] port_one_in // Port pin levels
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------------
    // Pin levels
    // ------------------------------------------------------------------
    // Lines carry pull-ups, so an open key never leaves a line floating
    // and a closed key pulls its line low
    assign port_one_in = ~key_down;

endmodule : kli_keypad

// ---- verification/keyboard_level_interrupt_test.sv ----
// Self-checking bench of the keyboard level interrupt unit
`include "kli_defs.svh"

module keyboard_level_interrupt_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] key_down = 8'h00;
    logic [7:0] port_one_in;
    logic [7:0] key_line_alt;
    logic keypad_irq_request;
    logic wake_request;
    int err_count = 0;
    int n_tests = 0;
    int seed = 8889;
    int lvl, en, flg, hit, k, d;
    logic [31:0] rd;
    logic er;

    always #4 sys_clk = ~sys_clk;

    kli_top u_kli_top
    (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .port_one_in(port_one_in),
        .key_line_alt(key_line_alt),
        .keypad_irq_request(keypad_irq_request),
        .wake_request(wake_request)
    );

    kli_keypad u_kli_keypad
    (
        .key_down(key_down),
        .port_one_in(port_one_in)
    );

    // ------------------------------------------------------------------
    // Bus and checking tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        if (err_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got,
                     exp);
        end
    endtask : chk

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h00000000);
        chk(rd, exp);
    endtask : rdchk

    // Samples away from the edge so design updates have landed
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : settle

    // ------------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------------
    initial
    begin
        repeat (8000) @(posedge sys_clk);
        err_count++;
        report_and_stop();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        settle(1);
        chk(keypad_irq_request, 0);
        chk(key_line_alt, 0);
        rdchk(`KLI_IDX_LEVEL, 0);
        rdchk(`KLI_IDX_ENABLE, 0);
        rdchk(`KLI_IDX_FLAGS, 0);
        rdchk(`KLI_IDX_CLEAR, 0);
        apb(1'b0, 8'h00, 32'h00000000);
        chk(er, 1);
        chk(rd, 0);
        // All lines high, then all lines low, each on its own level
        apb(1'b1, `KLI_IDX_LEVEL, 32'h000000FF);
        settle(1);
        rdchk(`KLI_IDX_FLAGS, 32'h000000FF);
        key_down <= 8'hFF;
        apb(1'b1, `KLI_IDX_LEVEL, 32'h00000000);
        apb(1'b1, `KLI_IDX_CLEAR, 32'h000000FF);
        rdchk(`KLI_IDX_FLAGS, 32'h000000FF);
        for (int i = 0; i < 8; i++)
        begin
            lvl = $random(seed) & 32'hFF;
            en = $random(seed) & 32'hFF;
            k = $random(seed) & 32'hFF;
            d = $random(seed) & 32'hFF;
            hit = (k ^ lvl) & 32'hFF;
            apb(1'b1, `KLI_IDX_LEVEL, lvl);
            key_down <= lvl[7:0];
            settle(2);
            apb(1'b1, `KLI_IDX_CLEAR, 32'h000000FF);
            rdchk(`KLI_IDX_LEVEL, lvl);
            rdchk(`KLI_IDX_FLAGS, 0);
            apb(1'b1, `KLI_IDX_ENABLE, en);
            apb(1'b1, `KLI_IDX_GIEN, i & 1);
            rdchk(`KLI_IDX_GIEN, i & 1);
            rdchk(`KLI_IDX_ENABLE, en);
            chk(key_line_alt, en);
            key_down <= k[7:0];
            settle(3);
            flg = hit;
            chk(keypad_irq_request, (i & 1) && (flg & en) != 0);
            chk(wake_request, (en & hit) != 0);
            rdchk(`KLI_IDX_FLAGS, flg);
            key_down <= lvl[7:0];
            settle(3);
            chk(wake_request, (en & flg) != 0);
            rdchk(`KLI_IDX_FLAGS, flg);
            apb(1'b1, `KLI_IDX_FLAGS, d);
            flg = flg & d;
            rdchk(`KLI_IDX_FLAGS, flg);
            settle(2);
            chk(keypad_irq_request, (i & 1) && (flg & en) != 0);
            key_down <= k[7:0];
            settle(1);
            apb(1'b1, `KLI_IDX_CLEAR, 32'h000000FF);
            rdchk(`KLI_IDX_FLAGS, hit);
        end
        report_and_stop();
    end

endmodule : keyboard_level_interrupt_test
